// [rtl/hpf_ctrl.v]
/*
 Pressure / force control path: differential pressure, command ramp,
 dual-set PID, feed forward, acceleration feedback, AXI4-Lite slave.
 Assumes sensors and position controller output are synchronous to
 aclk and hold steady between control ticks.
*/
`timescale 1ns/1ps
`include "hpf_ctrl_regs.vh"

module hpf_ctrl #(
   parameter        SW       = 24,
   parameter        VW       = 16,
   parameter [31:0] TICK_CYC = `HPF_TICK_CYC,
   parameter [31:0] P_FULL   = 32'h00061A80,
   parameter [31:0] OUT_FULL = 32'h00002710
) (
   // Clock and reset
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite write
   input  wire [6:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read
   input  wire [6:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Process inputs
   input  wire [SW-1:0] pressure_sensor_a,
   input  wire [SW-1:0] pressure_sensor_b,
   input  wire [VW-1:0] pos_ctrl_out,
   input  wire [VW-1:0] velocity_demand,
   input  wire          move_dir_b,
   // Outputs
   output reg  [VW-1:0] valve_cmd,
   output reg  [SW-1:0] diff_pressure_value,
   output reg  [15:0]   loop_gain,
   output reg  [SW-1:0] accel_value,
   output reg           control_tick
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function signed [47:0] lim;
      input signed [47:0] v;
      input signed [47:0] lo;
      input signed [47:0] hi;
      begin
         lim = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   function signed [47:0] sx;
      input [31:0] r;
      begin
         sx = {{16{r[31]}}, r};
      end
   endfunction

   function [31:0] rst_val;
      input [4:0] i;
      begin
         case (i)
            `HPF_AREA_RATIO: rst_val = `HPF_RST_RATIO;
            `HPF_SET1_BASE + `HPF_PS_DT1,
            `HPF_SET2_BASE + `HPF_PS_DT1: rst_val = `HPF_RST_DT1;
            `HPF_RAMP_UP, `HPF_RAMP_DN, `HPF_AFC_TIME,
            `HPF_V0_A, `HPF_V0_B, `HPF_V0AFC_A,
            `HPF_V0AFC_B: rst_val = `HPF_RST_ONE;
            default: rst_val = `HPF_RST_ZERO;
         endcase
      end
   endfunction

   localparam signed [47:0] TS = `HPF_TICK_US / 100;

   // ----------------------------------------------------------------
   // Register file and AXI4-Lite slave
   // ----------------------------------------------------------------
   reg [31:0] rf_reg [0:23];
   reg [4:0]  aw_idx_reg;
   reg        aw_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg        w_full_reg;
   reg signed [47:0] cmd_reg, integ_reg, dfilt_reg, eprev_reg;
   reg signed [47:0] alp_reg, pid_reg;
   reg [31:0] tick_cnt_reg;
   integer    k;

   assign s_axi_awready = ~aw_full_reg;
   assign s_axi_wready  = ~w_full_reg;
   assign s_axi_arready = ~s_axi_rvalid;

   wire do_wr = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   wire [4:0] ar_idx = s_axi_araddr[6:2];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_idx_reg   <= 5'h00;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h00000000;
         for (k = 0; k < 24; k = k + 1)
            rf_reg[k] <= rst_val(k[4:0]);
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[6:2];
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Status words are read only; writes there are refused
            if (aw_idx_reg <= `HPF_RW_LAST) begin
               s_axi_bresp <= 2'h0;
               for (k = 0; k < 4; k = k + 1)
                  if (w_strb_reg[k])
                     rf_reg[aw_idx_reg][k*8 +: 8] <= w_data_reg[k*8 +: 8];
            end else
               s_axi_bresp <= 2'h2;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (ar_idx)
               `HPF_DIFF_P:   s_axi_rdata <=
                  {{(32-SW){diff_pressure_value[SW-1]}}, diff_pressure_value};
               `HPF_RAMP_CMD: s_axi_rdata <= cmd_reg[31:0];
               `HPF_PID_OUT:  s_axi_rdata <= pid_reg[31:0];
               `HPF_VALVE:    s_axi_rdata <= {{(32-VW){valve_cmd[VW-1]}},
                                             valve_cmd};
               default:
                  if (ar_idx <= `HPF_RW_LAST)
                     s_axi_rdata <= rf_reg[ar_idx];
                  else begin
                     s_axi_rdata <= 32'h00000000;
                     s_axi_rresp <= 2'h2;
                  end
            endcase
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control tick
   // ----------------------------------------------------------------
   // fixed tick
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_reg <= 32'h00000000;
         control_tick <= 1'b0;
      end else begin
         control_tick <= (tick_cnt_reg == TICK_CYC - 32'h00000001);
         if (tick_cnt_reg == TICK_CYC - 32'h00000001)
            tick_cnt_reg <= 32'h00000000;
         else
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // ----------------------------------------------------------------
   // Pressure path, ramp, PID, feed forward, acceleration
   // ----------------------------------------------------------------
   wire [31:0] ctl = rf_reg[`HPF_CTRL];
   wire [4:0]  pb  = ctl[`HPF_B_SETSEL] ? `HPF_SET2_BASE : `HPF_SET1_BASE;
   wire signed [47:0] sa = {{(48-SW){pressure_sensor_a[SW-1]}},
                            pressure_sensor_a};
   wire signed [47:0] sb = {{(48-SW){pressure_sensor_b[SW-1]}},
                            pressure_sensor_b};
   wire signed [47:0] pos_in = {{(48-VW){pos_ctrl_out[VW-1]}}, pos_ctrl_out};
   wire signed [47:0] vel = {{(48-VW){velocity_demand[VW-1]}},
                             velocity_demand};
   wire signed [47:0] ofull = {16'h0000, OUT_FULL};

   reg signed [47:0] ratio, dp, err, kp, ti, td, tf, ia, step, pterm;
   reg signed [47:0] integ_n, draw, dfilt_n, pid_n, ffg, ff, hp, acc;
   reg signed [47:0] alp_n, cmd_n, tgt, merged, valve_n, v0;
   reg               arm;

   always @* begin
      ratio = lim(sx(rf_reg[`HPF_AREA_RATIO]), 48'sd200, 48'sd5000);
      if (!ctl[`HPF_B_SENSOR2])
         dp = sa;
      else if (ratio >= 48'sd1000)
         dp = sa - sb * 48'sd1000 / ratio;
      else
         dp = sa * ratio / 48'sd1000 - sb;
      if (ctl[`HPF_B_INVERT])
         dp = -dp;
      dp = dp + lim(sx(rf_reg[`HPF_P_OFFSET]), -48'sd50000, 48'sd50000);
      tgt = sx(rf_reg[`HPF_SETPOINT]);
      step = {16'h0000, P_FULL} / lim(sx(rf_reg[(tgt > cmd_reg) ?
             `HPF_RAMP_UP : `HPF_RAMP_DN]), 48'sd1, 48'sd600000);
      if (step < 48'sd1)
         step = 48'sd1;
      if (tgt > cmd_reg)
         cmd_n = (tgt - cmd_reg > step) ? cmd_reg + step : tgt;
      else
         cmd_n = (cmd_reg - tgt > step) ? cmd_reg - step : tgt;
      kp = lim(sx(rf_reg[pb + `HPF_PS_P]), 48'sd0, 48'sd10000);
      ti = lim(sx(rf_reg[pb + `HPF_PS_I]), 48'sd0, 48'sd30000);
      td = lim(sx(rf_reg[pb + `HPF_PS_D]), 48'sd0, 48'sd1200);
      tf = lim(sx(rf_reg[pb + `HPF_PS_DT1]), 48'sd10, 48'sd1000);
      ia = lim(sx(rf_reg[pb + `HPF_PS_IACT]), 48'sd0, 48'sd10000);
      err = cmd_reg - dp;
      pterm = err * kp / 48'sd100;
      arm = dp * 48'sd10000 > ia * $signed({16'h0000, P_FULL});
      if (ti == 48'sd0)
         integ_n = 48'sd0;
      else if (arm)
         integ_n = lim(integ_reg + err * kp * TS / (ti * 48'sd100),
                       -ofull, ofull);
      else
         integ_n = integ_reg;
      draw = (err - eprev_reg) * kp * td / (TS * 48'sd100);
      dfilt_n = dfilt_reg + (draw - dfilt_reg) * TS / (tf + TS);
      pid_n = lim(pterm + integ_n + dfilt_n, -ofull, ofull);
      ffg = lim(sx(rf_reg[move_dir_b ? `HPF_FF_B : `HPF_FF_A]),
                48'sd0, 48'sd15000);
      ff = (move_dir_b ? ctl[`HPF_B_FF_B] : ctl[`HPF_B_FF_A]) ?
           vel * ffg / 48'sd100 : 48'sd0;
      alp_n = alp_reg + (dp - alp_reg) /
              lim(sx(rf_reg[`HPF_AFC_TIME]), 48'sd1, 48'sd1000);
      hp = dp - alp_reg;
      acc = hp * lim(sx(rf_reg[`HPF_AFC_GAIN]), 48'sd0, 48'sd1000) /
            48'sd100;
      merged = pos_in + ff - (ctl[`HPF_B_AFC] ? acc : 48'sd0);
      if (ctl[`HPF_B_ENABLE] && ctl[`HPF_B_EXCL])
         valve_n = pid_reg;
      else if (ctl[`HPF_B_ENABLE])
         valve_n = ctl[`HPF_B_INVERT] ?
                   ((pid_reg > merged) ? pid_reg : merged) :
                   ((pid_reg < merged) ? pid_reg : merged);
      else
         valve_n = merged;
      valve_n = lim(valve_n, -ofull, ofull);
      v0 = lim(sx(rf_reg[ctl[`HPF_B_AFC] ?
               (move_dir_b ? `HPF_V0AFC_B : `HPF_V0AFC_A) :
               (move_dir_b ? `HPF_V0_B : `HPF_V0_A)]), 48'sd1, 48'sd400);
   end

   // Gain follows the bit immediately; the filters wait for the tick
   always @(posedge aclk) begin
      if (!aresetn) begin
         cmd_reg             <= 48'sd0;
         integ_reg           <= 48'sd0;
         dfilt_reg           <= 48'sd0;
         eprev_reg           <= 48'sd0;
         alp_reg             <= 48'sd0;
         pid_reg             <= 48'sd0;
         valve_cmd           <= {VW{1'b0}};
         diff_pressure_value <= {SW{1'b0}};
         accel_value         <= {SW{1'b0}};
         loop_gain           <= 16'h0001;
      end else begin
         loop_gain <= v0[15:0];
         if (control_tick) begin
            cmd_reg             <= cmd_n;
            integ_reg           <= integ_n;
            dfilt_reg           <= dfilt_n;
            eprev_reg           <= err;
            alp_reg             <= alp_n;
            pid_reg             <= pid_n;
            valve_cmd           <= valve_n[VW-1:0];
            diff_pressure_value <= dp[SW-1:0];
            accel_value         <= acc[SW-1:0];
         end
      end
   end

endmodule // hpf_ctrl

// [rtl/hpf_ctrl_regs.vh]
/*
 Register offsets, control bit positions, reset values and timing
 counts of the pressure / force controller.
 Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef HPF_CTRL_REGS_VH
`define HPF_CTRL_REGS_VH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define HPF_CTRL       5'h00
`define HPF_RAMP_UP    5'h01
`define HPF_RAMP_DN    5'h02
`define HPF_P_OFFSET   5'h03
`define HPF_AREA_RATIO 5'h04
`define HPF_SETPOINT   5'h05
`define HPF_SET1_BASE  5'h06
`define HPF_SET2_BASE  5'h0B
`define HPF_FF_A       5'h10
`define HPF_FF_B       5'h11
`define HPF_AFC_GAIN   5'h12
`define HPF_AFC_TIME   5'h13
`define HPF_V0_A       5'h14
`define HPF_V0_B       5'h15
`define HPF_V0AFC_A    5'h16
`define HPF_V0AFC_B    5'h17
`define HPF_RW_LAST    5'h17
`define HPF_DIFF_P     5'h18
`define HPF_RAMP_CMD   5'h19
`define HPF_PID_OUT    5'h1A
`define HPF_VALVE      5'h1B

// ----------------------------------------------------------------
// Offsets inside one parameter set
// ----------------------------------------------------------------
`define HPF_PS_P       5'h00
`define HPF_PS_I       5'h01
`define HPF_PS_D       5'h02
`define HPF_PS_DT1     5'h03
`define HPF_PS_IACT    5'h04

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define HPF_B_ENABLE   0
`define HPF_B_EXCL     1
`define HPF_B_INVERT   2
`define HPF_B_SENSOR2  3
`define HPF_B_SETSEL   4
`define HPF_B_FF_A     5
`define HPF_B_FF_B     6
`define HPF_B_AFC      7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define HPF_RST_ZERO   32'h00000000
`define HPF_RST_ONE    32'h00000001
`define HPF_RST_RATIO  32'h000003E8
`define HPF_RST_DT1    32'h0000000A
`define HPF_CLK_KHZ    25000
`define HPF_TICK_US    1000
`define HPF_TICK_CYC   (`HPF_TICK_US * `HPF_CLK_KHZ / 1000)

`endif

// [tb/hpf_ctrl_chk.sv]
/*
 Port checker for the pressure / force controller.
 Assumes it is bound to the top module with its tick parameter.
*/
`timescale 1ns/1ps
module hpf_ctrl_chk #(
   parameter [31:0] TICK_CYC = 32'h00000014
) (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Control path
   input wire [23:0] diff_pressure_value,
   input wire [15:0] valve_cmd,
   input wire [23:0] accel_value,
   input wire [15:0] loop_gain,
   input wire        control_tick
);
   // ------------------------------------------------------------
   // Tick spacing counter
   // ------------------------------------------------------------
   reg [31:0] gap_reg;
   reg        seen_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         gap_reg  <= 32'h0;
         seen_reg <= 1'b0;
      end else if (control_tick) begin
         gap_reg  <= 32'h0;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 32'h1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_tick_pulse: assert property (control_tick |=> !control_tick)
      else $error("tick longer than one cycle");
   a_tick_period: assert property (control_tick && seen_reg |->
      gap_reg == TICK_CYC - 32'h1) else $error("tick spacing wrong");
   a_diff_tick: assert property (!$past(control_tick) |->
      $stable(diff_pressure_value)) else $error("pressure off tick");
   a_valve_tick: assert property (!$past(control_tick) |->
      $stable(valve_cmd)) else $error("valve moved off tick");
   a_accel_tick: assert property (!$past(control_tick) |->
      $stable(accel_value)) else $error("accel moved off tick");
   a_gain_range: assert property (loop_gain >= 16'h0001 &&
      loop_gain <= 16'h0190) else $error("loop gain out of range");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
endmodule // hpf_ctrl_chk

bind hpf_ctrl hpf_ctrl_chk #(.TICK_CYC(TICK_CYC)) u_hpf_ctrl_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .diff_pressure_value(diff_pressure_value),
   .valve_cmd(valve_cmd), .accel_value(accel_value),
   .loop_gain(loop_gain), .control_tick(control_tick));

// [tb/hpf_proc_model.sv]
/*
 Process side model: sensors and position controller values.
 Assumes the bench sets the wanted values; they reach the
 controller only at a control tick, so they stay steady between.
*/
`timescale 1ns/1ps
module hpf_proc_model (
   // Clock, reset, tick
   input wire         aclk,
   input wire         aresetn,
   input wire         control_tick,
   // Wanted values
   input wire  [23:0] a_set,
   input wire  [23:0] b_set,
   input wire  [15:0] pos_set,
   input wire         dir_set,
   // Process outputs
   output logic [23:0] pressure_sensor_a,
   output logic [23:0] pressure_sensor_b,
   output logic [15:0] pos_ctrl_out,
   output logic        move_dir_b
);
   always @(posedge aclk) begin
      if (!aresetn) begin
         pressure_sensor_a <= 24'h000000;
         pressure_sensor_b <= 24'h000000;
         pos_ctrl_out      <= 16'h0000;
         move_dir_b        <= 1'b0;
      end else if (control_tick) begin
         pressure_sensor_a <= a_set;
         pressure_sensor_b <= b_set;
         pos_ctrl_out      <= pos_set;
         move_dir_b        <= dir_set;
      end
   end
endmodule // hpf_proc_model

// [tb/hpf_ctrl_tb.sv]
/*
 Register bus tests of the pressure / force controller.
 Assumes a short control tick of 20 clocks.
*/
`timescale 1ns/1ps
`include "hpf_ctrl_regs.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   err_count++; $display("Error %s exp %0h got %0h", nm, ex, got); end end
module hpf_ctrl_tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic dir_set = 0, tick;
   logic [6:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp, rsp;
   logic [23:0] a_set = 0, b_set = 0, sa, sb, diff, accel;
   logic [15:0] pos_set = 0, vel = 0, pos, gain, valve;
   logic mdir;
   logic [31:0] rd;
   int err_count = 0, checks_done = 0;

   always #20 aclk = ~aclk;

   hpf_ctrl #(.TICK_CYC(32'h00000014)) u_hpf_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pressure_sensor_a(sa),
      .pressure_sensor_b(sb), .pos_ctrl_out(pos),
      .velocity_demand(vel), .move_dir_b(mdir), .valve_cmd(valve),
      .diff_pressure_value(diff), .loop_gain(gain),
      .accel_value(accel), .control_tick(tick));

   hpf_proc_model u_hpf_proc_model (
      .aclk(aclk), .aresetn(aresetn), .control_tick(tick),
      .a_set(a_set), .b_set(b_set), .pos_set(pos_set),
      .dir_set(dir_set), .pressure_sensor_a(sa),
      .pressure_sensor_b(sb), .pos_ctrl_out(pos), .move_dir_b(mdir));

   task automatic close_out();
      $display("Counts: %0d checks, %0d errors", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic limit(input int n);
      if (n >= 200) begin
         err_count++;
         $display("Error wait limit exp done got hang");
         close_out();
      end
   endtask

   // Ready is sampled mid-cycle, valid released on the next rising edge
   task automatic wr(input logic [4:0] idx, input logic [31:0] d);
      int n;
      logic at, wt, ad, wd, done;
      ad = 0; wd = 0; done = 0; n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'h0}; wdata <= d; awvalid <= 1; wvalid <= 1;
      bready <= 1;
      while (!done && n < 200) begin
         @(negedge aclk);
         at = awvalid & awready;
         wt = wvalid & wready;
         done = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (at) awvalid <= 0;
         if (wt) wvalid <= 0;
         n++;
      end
      bready <= 0;
      limit(n);
   endtask

   task automatic rdr(input logic [4:0] idx);
      int n;
      logic at, done;
      done = 0; n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'h0}; arvalid <= 1; rready <= 1;
      while (!done && n < 200) begin
         @(negedge aclk);
         at = arvalid & arready;
         done = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (at) arvalid <= 0;
         n++;
      end
      rready <= 0;
      limit(n);
   endtask

   // Values land one tick after the model picks them up
   task automatic sync_tick();
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (!tick && n < 200);
      limit(n);
   endtask

   task automatic settle();
      repeat (3) sync_tick();
   endtask

   logic [4:0]  ri [9] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h09, 5'h0E,
                           5'h13, 5'h14, 5'h17};
   logic [31:0] rv [9] = '{32'h0, 32'h1, 32'h1, 32'h3E8, 32'hA, 32'hA,
                           32'h1, 32'h1, 32'h1};
   logic [7:0]  pc [5] = '{8'h00, 8'h08, 8'h08, 8'h0C, 8'h0C};
   logic [31:0] pr [5] = '{32'h7D0, 32'h7D0, 32'h1F4, 32'h7D0, 32'h7D0};
   logic [31:0] po [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h64};
   logic [23:0] pe [5] = '{24'h001388, 24'h000FA0, 24'hFFFC18,
                           24'hFFF060, 24'hFFF0C4};
   logic [7:0]  vc [6] = '{8'h00, 8'h01, 8'h01, 8'h05, 8'h05, 8'h03};
   logic [15:0] vp [6] = '{16'h01F4, 16'h01F4, 16'hFE0C, 16'h01F4,
                           16'hFE0C, 16'hFE0C};
   logic [15:0] ve [6] = '{16'h01F4, 16'h0000, 16'hFE0C, 16'h01F4,
                           16'h0000, 16'h0000};
   logic [7:0]  gc [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
   logic        gd [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [15:0] ge [4] = '{16'h0032, 16'h003C, 16'h0064, 16'h00C8};

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      // --------------------------------------------------------
      // Reset values and refused accesses
      // --------------------------------------------------------
      for (int i = 0; i < 9; i++) begin
         rdr(ri[i]);
         `CHK("reset value", rv[i], rd)
      end
      rdr(5'h1C);
      `CHK("unmapped read", 2'h2, rsp)
      wr(`HPF_DIFF_P, 32'h5);
      `CHK("read only write", 2'h2, rsp)
      $display("Test reset done");
      // --------------------------------------------------------
      // Differential pressure, ratio, invert, offset
      // --------------------------------------------------------
      a_set <= 24'h001770;
      b_set <= 24'h000FA0;
      for (int i = 0; i < 5; i++) begin
         wr(`HPF_AREA_RATIO, pr[i]);
         wr(`HPF_P_OFFSET, po[i]);
         wr(`HPF_CTRL, {24'h0, pc[i]});
         if (i == 0) a_set <= 24'h001388;
         else a_set <= 24'h001770;
         settle();
         `CHK("diff pressure", pe[i], diff)
      end
      $display("Test pressure done");
      // --------------------------------------------------------
      // Valve merge per mode, controller output held at zero
      // --------------------------------------------------------
      wr(`HPF_P_OFFSET, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(`HPF_CTRL, {24'h0, vc[i]});
         pos_set <= vp[i];
         settle();
         `CHK("valve", ve[i], valve)
      end
      $display("Test valve done");
      // --------------------------------------------------------
      // Loop gain switch with acceleration feedback
      // --------------------------------------------------------
      wr(`HPF_V0_A, 32'h32);
      wr(`HPF_V0_B, 32'h3C);
      wr(`HPF_V0AFC_A, 32'hC8);
      wr(`HPF_V0AFC_B, 32'h64);
      for (int i = 0; i < 4; i++) begin
         wr(`HPF_CTRL, {24'h0, gc[i]});
         dir_set <= gd[i];
         settle();
         `CHK("loop gain", ge[i], gain)
      end
      wr(`HPF_CTRL, 32'h0);
      settle();
      `CHK("fallback gain", 16'h0032, gain)
      $display("Test gain done");
      // --------------------------------------------------------
      // PID set select, proportional term, integrator gating
      // --------------------------------------------------------
      wr(`HPF_SET2_BASE + `HPF_PS_P, 32'h32);
      wr(`HPF_CTRL, 32'h10);
      settle();
      rdr(`HPF_PID_OUT);
      `CHK("pid set 2", 32'hFFFFF448, rd)
      wr(`HPF_SET2_BASE + `HPF_PS_IACT, 32'h2710);
      wr(`HPF_SET2_BASE + `HPF_PS_I, 32'h12C);
      settle();
      rdr(`HPF_PID_OUT);
      `CHK("pid unarmed", 32'hFFFFF448, rd)
      wr(`HPF_CTRL, 32'h14);
      wr(`HPF_SET2_BASE + `HPF_PS_IACT, 32'h0);
      settle();
      rdr(`HPF_PID_OUT);
      `CHK("pid negative p", 32'h00000BB8, rd)
      $display("Test pid done");
      // --------------------------------------------------------
      // Feed forward per direction, then command ramp
      // --------------------------------------------------------
      wr(`HPF_FF_A, 32'hC8);
      wr(`HPF_CTRL, 32'h20);
      vel <= 16'h0064;
      pos_set <= 16'h0000;
      settle();
      `CHK("feed forward a", 16'h00C8, valve)
      dir_set <= 1;
      settle();
      `CHK("feed forward b", 16'h0000, valve)
      // Align to a tick so the count of ramp steps is exact
      wr(`HPF_RAMP_UP, 32'h64);
      sync_tick();
      wr(`HPF_SETPOINT, 32'h4E20);
      settle();
      rdr(`HPF_RAMP_CMD);
      `CHK("ramp up", 32'h2EE0, rd)
      wr(`HPF_RAMP_DN, 32'hC8);
      sync_tick();
      wr(`HPF_SETPOINT, 32'h0);
      settle();
      rdr(`HPF_RAMP_CMD);
      `CHK("ramp down", 32'h2710, rd)
      $display("Test ff and ramp done");
      close_out();
   end
endmodule // hpf_ctrl_tb
